// [pkg/sss_map.svh]
// Purpose: Offsets, timing figures and reset values for the startup supervisor
// Assumes: Clock of 10 MHz; times given in microseconds except the state timeout
// Notes:   Cycle counts are derived from the time figures by expression, except the state timeout given in cycles
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH
`define SSS_CLK_KHZ          10000
`define SSS_RESET_OUT_N_HOLD_US     2000
`define SSS_RESET_OUT_N_HOLD_CYC    ((`SSS_RESET_OUT_N_HOLD_US * `SSS_CLK_KHZ) / 1000)
`define SSS_WD_WINDOW_US     20000
`define SSS_WD_WINDOW_CYC    ((`SSS_WD_WINDOW_US * `SSS_CLK_KHZ) / 1000)
`define SSS_WD_TIMEOUT_US    300000
`define SSS_WD_TIMEOUT_CYC   ((`SSS_WD_TIMEOUT_US * `SSS_CLK_KHZ) / 1000)
`define SSS_STATE_TMO_CYC    50000
`define SSS_RESET_LIMIT      4
`define SSS_NVM_WORDS        16
`define SSS_NVM_AW           4
`define SSS_RAILS            6
`endif

// [pkg/sss_pkg.sv]
// Purpose: Types shared by the startup supervisor files
// Assumes: Nothing beyond the map header
// Notes:   States carry explicit binary codes
package sss_pkg;
	typedef enum logic [2:0] {
		ST_CFG_LOAD  = 3'h0,
		ST_TEST_BEG  = 3'h1,
		ST_TEST_END  = 3'h2,
		ST_THR_CHK   = 3'h3,
		ST_RAMP      = 3'h4,
		ST_ACTIVE    = 3'h5,
		ST_LP_OFF    = 3'h6
	} sss_state_e;
	typedef enum logic [1:0] {
		WD_WAIT_EN = 2'h0,
		WD_CLOSED  = 2'h1,
		WD_OPEN    = 2'h2,
		WD_HOLD    = 2'h3
	} sss_wd_e;
endpackage

// [design/sss_nvm_reader.sv]
// Purpose: Sequential reader of configuration words with checksum check
// Assumes: Nonvolatile memory gives data in the same cycle as the address
// Notes:   Last word holds the two's complement of the sum of the others
`timescale 1ns/10ps
`include "sss_map.svh"
module sss_nvm_reader #(
	parameter int WORDS = `SSS_NVM_WORDS,
	parameter int AW    = `SSS_NVM_AW
) (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          start,
	output logic [AW-1:0]      nvm_addr,
	input  wire logic [7:0]    nvm_data,
	output logic               done,
	output logic               sum_ok,
	output logic [7:0]         cfg_word0
);
	logic [AW-1:0] addr_q, addr_d;
	logic [7:0]    sum_q, sum_d, w0_q, w0_d;
	logic          busy_q, busy_d, done_q, done_d, ok_q, ok_d, vld_q, vld_d;

	// Walk all words once; data are taken in the cycle their address is driven
	always_comb begin
		addr_d = addr_q;
		sum_d  = sum_q;
		w0_d   = w0_q;
		busy_d = busy_q;
		done_d = done_q;
		ok_d   = ok_q;
		vld_d  = 1'b0;
		if (start && !busy_q && !done_q) begin
			busy_d = 1'b1;
			addr_d = '0;
			sum_d  = 8'h00;
			vld_d  = 1'b1;
		end else if (busy_q) begin
			if (vld_q) begin
				sum_d = sum_q + nvm_data;
				if (addr_q == '0)
					w0_d = nvm_data;
			end
			if (addr_q == AW'(WORDS - 1) && vld_q) begin
				busy_d = 1'b0;
				done_d = 1'b1;
				ok_d   = ((sum_q + nvm_data) == 8'h00);
			end else if (vld_q) begin
				addr_d = addr_q + 1'b1;
				vld_d  = 1'b1;
			end
		end
	end

	// State registers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			addr_q <= '0;
			sum_q  <= 8'h00;
			w0_q   <= 8'h00;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			ok_q   <= 1'b0;
			vld_q  <= 1'b0;
		end else begin
			addr_q <= addr_d;
			sum_q  <= sum_d;
			w0_q   <= w0_d;
			busy_q <= busy_d;
			done_q <= done_d;
			ok_q   <= ok_d;
			vld_q  <= vld_d;
		end
	end

	assign nvm_addr  = addr_q;
	assign done      = done_q;
	assign sum_ok    = ok_q;
	assign cfg_word0 = w0_q;
endmodule

// [design/sss_supervisor.sv]
// Purpose: Start-up sequencing, self-test and window watchdog supervision
// Assumes: rstn is the power-on reset; analog inputs are asynchronous
// Notes:   Configuration word 0 bit 0 enables the final watchdog reset
`timescale 1ns/10ps
`include "sss_map.svh"
module sss_supervisor #(
	parameter int STATE_TMO_CYC  = `SSS_STATE_TMO_CYC,
	parameter int RESET_LIMIT    = `SSS_RESET_LIMIT,
	parameter int HOLD_CYC       = `SSS_RESET_OUT_N_HOLD_CYC,
	parameter int WINDOW_CYC     = `SSS_WD_WINDOW_CYC,
	parameter int EN_TIMEOUT_CYC = `SSS_WD_TIMEOUT_CYC,
	parameter int RAILS          = `SSS_RAILS
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             wake_in,
	input  wire logic             window_trigger_in,
	input  wire logic             reg_uv_in,
	input  wire logic             temp_threshold_pin,
	input  wire logic [RAILS-1:0] rail_uv_in,
	input  wire logic [RAILS-1:0] rail_ov_in,
	input  wire logic             overtemp_in,
	input  wire logic             thr_ok_in,
	input  wire logic             ramp_done_in,
	input  wire logic             wd_flag_clr,
	output logic [`SSS_NVM_AW-1:0] nvm_addr,
	input  wire logic [7:0]       nvm_data,
	output logic                  reset_out_n,
	output logic                  wd_reset_flag,
	output logic [7:0]            error_count,
	output logic [2:0]            state_out
);
	localparam int IN_W = 2 * RAILS + 6;
	logic [IN_W-1:0] s1_q, s2_q;
	logic            wake, trig, reg_uv, tpin, otemp, thr_ok, rdone, clr;
	logic [RAILS-1:0] uv, ov;

	// Two-stage synchronisers for every asynchronous input
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {wake_in, window_trigger_in, reg_uv_in, temp_threshold_pin,
				overtemp_in, wd_flag_clr, rail_uv_in, rail_ov_in};
			s2_q <= s1_q;
		end
	end

	// Threshold and ramp status get synchroniser pairs of their own
	logic thr_q1, thr_q2, rd_q1, rd_q2;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			thr_q1 <= 1'b0;
			thr_q2 <= 1'b0;
			rd_q1  <= 1'b0;
			rd_q2  <= 1'b0;
		end else begin
			thr_q1 <= thr_ok_in;
			thr_q2 <= thr_q1;
			rd_q1  <= ramp_done_in;
			rd_q2  <= rd_q1;
		end
	end

	assign wake   = s2_q[IN_W-1];
	assign trig   = s2_q[IN_W-2];
	assign reg_uv = s2_q[IN_W-3];
	assign tpin   = s2_q[IN_W-4];
	assign otemp  = s2_q[IN_W-5];
	assign clr    = s2_q[2*RAILS];
	assign uv     = s2_q[2*RAILS-1:RAILS];
	assign ov     = s2_q[RAILS-1:0];
	assign thr_ok = thr_q2;
	assign rdone  = rd_q2;

	// Configuration reader; runs once per power cycle in the load state
	logic                nvm_done, nvm_ok;
	logic [7:0]          cfg0;
	sss_pkg::sss_state_e st_q, st_d;
	sss_nvm_reader #(
		.WORDS (`SSS_NVM_WORDS),
		.AW    (`SSS_NVM_AW)
	) u_nvm (
		.clk       (clk),
		.rstn      (rstn),
		.start     (st_q == sss_pkg::ST_CFG_LOAD),
		.nvm_addr  (nvm_addr),
		.nvm_data  (nvm_data),
		.done      (nvm_done),
		.sum_ok    (nvm_ok),
		.cfg_word0 (cfg0)
	);

	// Watchdog, error count and mode timer state
	sss_pkg::sss_wd_e wd_q, wd_d;
	logic [31:0]      wcnt_q, wcnt_d, tmr_q, tmr_d;
	logic [7:0]       ec_q, ec_d;
	logic             trig_q, trig_d, flag_q, flag_d, rn_q, rn_d;
	logic             trig_rise, wd_fail, lim_hit, step_ok;

	// Edge detector rests low, matching the idle trigger level
	assign trig_rise = trig && !trig_q;

	// Window watchdog: closed quarter, then open until the window ends;
	// one counter runs from the last accepted edge so both limits share it
	always_comb begin
		wd_d    = wd_q;
		wcnt_d  = wcnt_q + 32'h1;
		wd_fail = 1'b0;
		trig_d  = trig;
		if (st_q != sss_pkg::ST_ACTIVE) begin
			wd_d   = sss_pkg::WD_WAIT_EN;
			wcnt_d = '0;
		end else begin
			case (wd_q)
			sss_pkg::WD_WAIT_EN: begin
				if (trig_rise) begin
					wd_d   = sss_pkg::WD_CLOSED;
					wcnt_d = '0;
				end else if (wcnt_q >= 32'(EN_TIMEOUT_CYC - 1)) begin
					wd_fail = 1'b1;
				end
			end
			sss_pkg::WD_CLOSED: begin
				if (trig_rise) begin
					wd_fail = 1'b1;
				end else if (wcnt_q >= 32'(WINDOW_CYC / 4 - 1)) begin
					wd_d = sss_pkg::WD_OPEN;
				end
			end
			sss_pkg::WD_OPEN: begin
				if (trig_rise) begin
					wd_d   = sss_pkg::WD_CLOSED;
					wcnt_d = '0;
				end else if (wcnt_q >= 32'(WINDOW_CYC - 1)) begin
					wd_fail = 1'b1;
				end
			end
			sss_pkg::WD_HOLD: begin
				if (wcnt_q >= 32'(HOLD_CYC - 1)) begin
					wd_d   = sss_pkg::WD_WAIT_EN;
					wcnt_d = '0;
				end
			end
			default: begin
				wd_d = sss_pkg::WD_WAIT_EN;
			end
			endcase
			if (wd_fail) begin
				wd_d   = sss_pkg::WD_HOLD;
				wcnt_d = '0;
			end
		end
	end

	// Flag and error count; a failure in the clear cycle keeps the flag
	always_comb begin
		ec_d   = ec_q;
		flag_d = flag_q;
		if (clr) begin
			flag_d = 1'b0;
		end
		if (wd_fail) begin
			flag_d = 1'b1;
			if (ec_q != 8'hff) begin
				ec_d = ec_q + 8'h01;
			end
		end
	end

	assign lim_hit = ec_d > 8'(RESET_LIMIT);

	// Start-up sequence; each mode only moves on when its checks pass
	always_comb begin
		st_d    = st_q;
		step_ok = 1'b0;
		case (st_q)
		sss_pkg::ST_CFG_LOAD: begin
			step_ok = nvm_done && nvm_ok && !reg_uv;
		end
		sss_pkg::ST_TEST_BEG: begin
			step_ok = tpin && (&uv) && (&ov);
		end
		sss_pkg::ST_TEST_END: begin
			step_ok = (&uv) && !(|ov) && !otemp;
		end
		sss_pkg::ST_THR_CHK: begin
			step_ok = thr_ok;
		end
		sss_pkg::ST_RAMP: begin
			step_ok = rdone;
		end
		default: begin
			step_ok = 1'b0;
		end
		endcase
		case (st_q)
		sss_pkg::ST_CFG_LOAD: begin
			if (step_ok) begin
				st_d = sss_pkg::ST_TEST_BEG;
			end
		end
		sss_pkg::ST_TEST_BEG, sss_pkg::ST_TEST_END, sss_pkg::ST_THR_CHK,
		sss_pkg::ST_RAMP: begin
			if (step_ok) begin
				case (st_q)
				sss_pkg::ST_TEST_BEG: st_d = sss_pkg::ST_TEST_END;
				sss_pkg::ST_TEST_END: st_d = sss_pkg::ST_THR_CHK;
				sss_pkg::ST_THR_CHK:  st_d = sss_pkg::ST_RAMP;
				default:              st_d = sss_pkg::ST_ACTIVE;
				endcase
			end else if (!wake && tmr_q >= 32'(STATE_TMO_CYC - 1)) begin
				st_d = sss_pkg::ST_LP_OFF;
			end
			// Wake high keeps a failed mode where it is
		end
		sss_pkg::ST_ACTIVE: begin
			if (wd_q == sss_pkg::WD_HOLD && wcnt_q >= 32'(HOLD_CYC - 1)
				&& lim_hit) begin
				st_d = sss_pkg::ST_LP_OFF;
			end else if (wd_fail && lim_hit && !cfg0[0]) begin
				st_d = sss_pkg::ST_LP_OFF;
			end
		end
		default: begin
			st_d = st_q;
		end
		endcase
	end

	// Mode timer restarts on every mode change and saturates
	always_comb begin
		tmr_d = tmr_q;
		if (st_d != st_q) begin
			tmr_d = '0;
		end else if (tmr_q != 32'hffffffff) begin
			tmr_d = tmr_q + 32'h1;
		end
	end

	// Reset output is low outside active and during the hold
	assign rn_d = (st_d == sss_pkg::ST_ACTIVE) && (wd_d != sss_pkg::WD_HOLD);

	// State registers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_q   <= sss_pkg::ST_CFG_LOAD;
			wd_q   <= sss_pkg::WD_WAIT_EN;
			wcnt_q <= '0;
			tmr_q  <= '0;
			ec_q   <= 8'h00;
			trig_q <= 1'b0;
			flag_q <= 1'b0;
			rn_q   <= 1'b0;
		end else begin
			st_q   <= st_d;
			wd_q   <= wd_d;
			wcnt_q <= wcnt_d;
			tmr_q  <= tmr_d;
			ec_q   <= ec_d;
			trig_q <= trig_d;
			flag_q <= flag_d;
			rn_q   <= rn_d;
		end
	end

	assign reset_out_n   = rn_q;
	assign wd_reset_flag = flag_q;
	assign error_count   = ec_q;
	assign state_out     = st_q;
endmodule

// [bench/sss_chk_properties.sv]
// Purpose: Port relations of the startup supervisor
// Assumes: rstn low is the power-on reset
// Notes:   Bound into every supervisor instance
`timescale 1ns/10ps
module sss_chk #(parameter int RESET_LIMIT = 4, RAILS = 6) (
	input logic             clk,
	input logic             rstn,
	input logic             wake_in,
	input logic             reg_uv_in,
	input logic [RAILS-1:0] rail_ov_in,
	input logic             reset_out_n,
	input logic             wd_reset_flag,
	input logic [7:0]       error_count,
	input logic [2:0]       state_out
);
	// Single domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	flag_set_a: assert property (
		$fell(reset_out_n) |-> ##[0:1] wd_reset_flag) else $error("no flag");
	count_step_a: assert property (
		$changed(error_count) |-> error_count == $past(error_count) + 8'h01)
		else $error("count step");
	hold_low_a: assert property (
		$fell(reset_out_n) |=> !reset_out_n [*8]) else $error("short reset");
	step_order_a: assert property (
		$changed(state_out) |-> state_out == $past(state_out) + 3'h1
		|| state_out == sss_pkg::ST_LP_OFF) else $error("bad order");
	off_limit_a: assert property (
		$changed(state_out) && state_out == sss_pkg::ST_LP_OFF
		&& $past(state_out) == sss_pkg::ST_ACTIVE
		|-> error_count >= RESET_LIMIT) else $error("early off");
	wake_stay_a: assert property (
		(wake_in && state_out inside {[3'h1:3'h4]}) [*3]
		|=> state_out != sss_pkg::ST_LP_OFF) else $error("off on wake");
	end_stay_a: assert property (
		(state_out == sss_pkg::ST_TEST_END && wake_in && |rail_ov_in) [*3]
		|=> state_out == sss_pkg::ST_TEST_END) else $error("left test end");
	uv_hold_a: assert property (
		(state_out == sss_pkg::ST_CFG_LOAD && reg_uv_in) [*3]
		|=> state_out == sss_pkg::ST_CFG_LOAD) else $error("left load");
	cover property (state_out == sss_pkg::ST_ACTIVE);
	cover property (state_out == sss_pkg::ST_LP_OFF);
	cover property ($fell(reset_out_n));
endmodule
bind sss_supervisor sss_chk #(.RESET_LIMIT(RESET_LIMIT), .RAILS(RAILS))
	chk (.*);

// [bench/sss_mcu.sv]
// Purpose: Supervised controller pulsing the watchdog trigger
// Assumes: Period sits between a quarter and a full window
// Notes:   Trigger rests low while disabled
`timescale 1ns/10ps
module sss_mcu #(parameter int PER = 30) (
	input logic  clk,
	input logic  en,
	output logic trig
);
	int n = 0;
	initial trig = 1'b0;
	// Three quarters of the window keeps clear of both edges
	always @(negedge clk) begin
		n <= en ? (n + 1) % PER : 0;
		trig <= en && n >= PER / 2;
	end
endmodule

// [bench/startup_safety_supervisor_bench.sv]
// Purpose: Scenario bench for the startup supervisor
// Assumes: Counts shortened by parameters
// Notes:   Comparator levels follow the state to pass the self-test
`timescale 1ns/10ps
module startup_safety_supervisor_bench;
	logic       clk = 0, rstn = 0, wake = 1, uv = 0, ov_bad = 0, en = 0;
	logic       trig, tp = 0, rn, flag, ot = 0, thr = 1, rd = 1, clr = 0;
	logic [5:0] r_uv = 0, r_ov = 0;
	logic [3:0] addr;
	logic [7:0] mem [16], ec;
	logic [2:0] st;
	int         n_errors = 0, num_checks = 0;
	always #50 clk = ~clk;
	sss_supervisor #(.STATE_TMO_CYC(60), .RESET_LIMIT(2), .HOLD_CYC(20),
		.WINDOW_CYC(40), .EN_TIMEOUT_CYC(100)) uut (.clk, .rstn,
		.wake_in(wake), .window_trigger_in(trig), .reg_uv_in(uv),
		.temp_threshold_pin(tp), .rail_uv_in(r_uv), .rail_ov_in(r_ov),
		.overtemp_in(ot), .thr_ok_in(thr), .ramp_done_in(rd),
		.wd_flag_clr(clr), .nvm_addr(addr), .nvm_data(mem[addr]),
		.reset_out_n(rn), .wd_reset_flag(flag), .error_count(ec),
		.state_out(st));
	sss_mcu #(.PER(30)) mcu (.clk, .en, .trig);
	// All comparators fail at test begin, only undervoltage at test end unless ov_bad is set
	always @(negedge clk) begin
		r_uv <= {6{st < sss_pkg::ST_THR_CHK}};
		r_ov <= {6{st == sss_pkg::ST_TEST_BEG || ov_bad}};
		tp <= st == sss_pkg::ST_TEST_BEG;
	end
	task chk(string nm, logic [7:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task results;
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Bounded wait; a miss ends the run
	task wait_st(logic [2:0] s, int lim);
		for (int i = 0; i < lim && st !== s; i++)
			@(negedge clk);
		chk("state", st, s);
		if (st !== s)
			results();
	endtask
	// Power cycle; last word completes the checksum when 8'hff
	task pwr(logic [7:0] last);
		rstn = 0;
		mem = '{0: 8'h01, 15: last, default: 8'h00};
		repeat (3) @(negedge clk);
		rstn = 1;
	endtask
	task t_badsum;
		pwr(8'h00);
		repeat (300) @(negedge clk);
		chk("crc", st, sss_pkg::ST_CFG_LOAD);
	endtask
	task t_stall;
		ov_bad = 1;
		pwr(8'hff);
		wait_st(sss_pkg::ST_TEST_END, 200);
		repeat (150) @(negedge clk);
		chk("hold", st, sss_pkg::ST_TEST_END);
		wake = 0;
		wait_st(sss_pkg::ST_LP_OFF, 100);
		{wake, ov_bad} = 2'h2;
	endtask
	task t_boot;
		uv = 1;
		pwr(8'hff);
		repeat (100) @(negedge clk);
		chk("uv", st, sss_pkg::ST_CFG_LOAD);
		thr = 0;
		uv = 0;
		wait_st(sss_pkg::ST_THR_CHK, 500);
		repeat (20) @(negedge clk);
		chk("thr", st, sss_pkg::ST_THR_CHK);
		thr = 1;
		wait_st(sss_pkg::ST_ACTIVE, 500);
		en = 1;
		repeat (300) @(negedge clk);
		chk("ec", ec, 8'h00);
	endtask
	task t_wdfail;
		en = 0;
		for (int i = 0; i < 200 && rn !== 0; i++)
			@(negedge clk);
		@(negedge clk);
		chk("flag", flag, 8'h01);
		chk("ec", ec, 8'h01);
		repeat (15) @(negedge clk);
		chk("rst", rn, 8'h00);
		wait_st(sss_pkg::ST_LP_OFF, 3000);
		clr = 1;
		repeat (4) @(negedge clk);
		chk("clr", flag, 8'h00);
		clr = 0;
	endtask
	initial begin
		t_badsum;
		t_stall;
		t_boot;
		t_wdfail;
		results();
	end
endmodule
